// ### hw/clk_source_switch.v
// glitch-free clock source select handshake: new source takes effect two cycles later, one cycle later when leaving none
`timescale 1ns/1ps
module clk_source_switch (
   // clock and reset
   input wire core_clk_in,
   input wire reset_n_in,
   // request
   input wire [1:0] want_src_in,
   // result
   output reg [1:0] cur_src_out,
   output reg switched_out
);
   // break before make: a change from a running source passes through the none source for one cycle
   reg gap_r;

   always @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cur_src_out <= 2'h0;
         gap_r <= 1'b0;
         switched_out <= 1'b0;
      end else begin
         switched_out <= 1'b0;
         if (gap_r) begin
            cur_src_out <= want_src_in;
            gap_r <= 1'b0;
            switched_out <= 1'b1;
         end else if (want_src_in != cur_src_out && cur_src_out != 2'h3) begin
            cur_src_out <= 2'h3;
            gap_r <= 1'b1;
         end else if (want_src_in != cur_src_out) begin
            cur_src_out <= want_src_in;
            switched_out <= 1'b1;
         end
      end
   end
endmodule

// ### hw/pm_clock_modes.v
// power-managed clock mode controller: mode machine, oscillator enables, status flags
`timescale 1ns/1ps
`include "pm_clock_regs.vh"

// Function
// - idle set, select hi set, sleep: internal idle, cpu stops, peripherals on mux
// - switching to internal mux stops primary oscillator and clears primary ready
// - nonzero frequency select sets stable flag after about 1 ms
// - stable flag stays set if already stable before sleep
// - zero frequency select: mux disabled, stable flag clear, slow rc clocks
// - wake from internal idle: cpu resumes on mux after 10 us
// - switchback from internal mode clears stable flag and sets primary ready
// - wake leaves idle enable and source select unchanged
// - slow rc keeps running after switchback if watchdog or monitor on
// - idle clear sleep, select nonzero: cpu and peripherals clocked from selected source
// - watchdog time-out in secondary or internal run gives a watchdog reset
// - all low-power modes return to primary run on interrupt or timeout
// - primary run has primary ready set
// - idle clear, select 01, sleep: secondary run, primary off, flags swap
// - sleep ignored for secondary when secondary oscillator enable clear
// - wake from secondary run switches back, secondary keeps running
// - clearing secondary enable exits secondary run, then secondary disabled
// - idle clear, select hi set, sleep: internal run, primary shut down
// - frequency select change takes effect at once without sleep
// - zero to nonzero frequency select sets stable flag after about 1 ms
// - idle set sleep in secondary or internal run halts cpu, flags unchanged
// - sleep from run mode stops primary and internal, clears all flags
// - idle and both select bits zero: sleep enters full sleep
module pm_clock_modes (
   // clock and reset
   input wire core_clk_in,
   input wire reset_n_in,
   // core requests
   input wire sleep_exec_in,
   input wire wake_event_in,
   input wire wdt_timeout_in,
   // control bits written by firmware
   input wire idle_enable_in,
   input wire [1:0] source_select_in,
   input wire [2:0] internal_freq_select_in,
   input wire secondary_osc_enable_in,
   input wire wdt_enable_in,
   input wire fscm_enable_in,
   // oscillator feedback
   input wire primary_osc_ready_in,
   // status flags
   output reg primary_ready_flag_out,
   output reg internal_osc_stable_flag_out,
   output reg secondary_active_flag_out,
   // clock control
   output reg cpu_clk_en_out,
   output reg periph_clk_en_out,
   output reg [1:0] sys_clk_src_out,
   output reg [2:0] internal_freq_out,
   output reg primary_osc_en_out,
   output reg internal_osc_mux_en_out,
   output reg secondary_osc_run_out,
   output reg slow_internal_rc_en_out,
   output reg wdt_reset_out,
   output reg [6:0] mode_out
);
   // ****************************************
   // modes
   // ****************************************
   localparam [6:0] M_PRIMARY_RUN = 7'h01;
   localparam [6:0] M_SECONDARY_RUN = 7'h02;
   localparam [6:0] M_INTERNAL_RUN = 7'h04;
   localparam [6:0] M_INTERNAL_IDLE = 7'h08;
   localparam [6:0] M_SECONDARY_IDLE = 7'h10;
   localparam [6:0] M_SLEEP = 7'h20;
   localparam [6:0] M_SWITCHBACK = 7'h40;

   reg [6:0] mode_r;
   reg [6:0] mode_nxt;
   reg [1:0] want_src_r;
   reg [1:0] want_src_nxt;
   reg cpu_wait_r;
   reg sec_off_after_r;
   reg sec_off_after_nxt;
   reg [2:0] freq_prev_r;
   reg halt_r;
   reg halt_nxt;

   wire [1:0] cur_src;
   wire switched;
   wire stab_busy;
   wire wake_busy;
   wire wake_done;

   function is_run_mode;
      input [6:0] m;
      begin
         is_run_mode = (m == M_SECONDARY_RUN) || (m == M_INTERNAL_RUN);
      end
   endfunction

   // ****************************************
   // clock switch and timers
   // ****************************************
   clk_source_switch u_switch (
      .core_clk_in(core_clk_in),
      .reset_n_in(reset_n_in),
      .want_src_in(want_src_r),
      .cur_src_out(cur_src),
      .switched_out(switched)
   );

   // mux output stabilisation, restarted when select leaves zero
   wire freq_on = (internal_freq_select_in != `FREQ_OFF);
   wire stab_start = freq_on && (freq_prev_r == `FREQ_OFF);
   // settled is a level, not the done pulse: a pulse landing on a switch edge would be lost
   wire mux_settled = freq_on && !stab_busy && !stab_start;
   // both counts fit the timer width; the upper bits are zero
   wire [31:0] stab_load = `STABLE_CYCLES;
   wire [31:0] wake_load = `CPU_WAKE_CYCLES;
   pm_delay_timer u_stab (
      .core_clk_in(core_clk_in),
      .reset_n_in(reset_n_in),
      .start_in(stab_start),
      .abort_in(!freq_on),
      .load_in(stab_load[15:0]),
      .busy_out(stab_busy),
      .done_out()
   );

   // an interrupt or a watchdog time-out both wake an idle mode
   wire wake_start = (wake_event_in || wdt_timeout_in)
      && (mode_r == M_INTERNAL_IDLE || mode_r == M_SECONDARY_IDLE);
   pm_delay_timer u_wake (
      .core_clk_in(core_clk_in),
      .reset_n_in(reset_n_in),
      .start_in(wake_start),
      .abort_in(1'b0),
      .load_in(wake_load[15:0]),
      .busy_out(wake_busy),
      .done_out(wake_done)
   );

   // ****************************************
   // mode machine
   // ****************************************
   always @* begin
      mode_nxt = mode_r;
      want_src_nxt = want_src_r;
      sec_off_after_nxt = sec_off_after_r;
      halt_nxt = halt_r;
      case (mode_r)
         M_PRIMARY_RUN: begin
            if (sleep_exec_in) begin
               if (!idle_enable_in && source_select_in == `SEL_PRIMARY) begin
                  mode_nxt = M_SLEEP;
                  want_src_nxt = `SRC_NONE;
               end else if (source_select_in[1]) begin
                  // lower select bit ignored
                  mode_nxt = idle_enable_in ? M_INTERNAL_IDLE : M_INTERNAL_RUN;
                  want_src_nxt = `SRC_INTERNAL;
                  halt_nxt = idle_enable_in;
               end else if (source_select_in == `SEL_SECONDARY && secondary_osc_enable_in) begin
                  mode_nxt = idle_enable_in ? M_SECONDARY_IDLE : M_SECONDARY_RUN;
                  want_src_nxt = `SRC_SECONDARY;
                  halt_nxt = idle_enable_in;
               end // else ignored
            end
         end
         M_SECONDARY_RUN, M_INTERNAL_RUN: begin
            if (wdt_timeout_in) begin
               // reset returns to primary once it has started
               mode_nxt = M_SWITCHBACK;
            end else if (mode_r == M_SECONDARY_RUN && !secondary_osc_enable_in) begin
               mode_nxt = M_SWITCHBACK;
               sec_off_after_nxt = 1'b1;
            end else if (wake_event_in) begin
               mode_nxt = M_SWITCHBACK;
            end else if (sleep_exec_in && idle_enable_in) begin
               // halt only, clocks and flags untouched
               mode_nxt = (mode_r == M_SECONDARY_RUN) ? M_SECONDARY_IDLE : M_INTERNAL_IDLE;
               halt_nxt = 1'b1;
            end else if (sleep_exec_in && source_select_in == `SEL_PRIMARY) begin
               mode_nxt = M_SLEEP;
               want_src_nxt = `SRC_NONE;
            end
         end
         M_INTERNAL_IDLE, M_SECONDARY_IDLE: begin
            if (wake_done) begin
               // cpu resumes on same clock
               mode_nxt = M_SWITCHBACK;
               halt_nxt = 1'b0;
            end
         end
         M_SLEEP: begin
            if (wake_event_in || wdt_timeout_in) begin
               // primary run only once the primary clocks the system
               mode_nxt = M_SWITCHBACK;
            end
         end
         M_SWITCHBACK: begin
            // stay on low-power source while primary starts
            // an early request would finish the switch and the completion pulse would be missed
            if (primary_osc_ready_in) begin
               want_src_nxt = `SRC_PRIMARY;
               if (switched && cur_src == `SRC_PRIMARY) begin
                  mode_nxt = M_PRIMARY_RUN;
                  sec_off_after_nxt = 1'b0;
               end
            end
         end
         default: begin
            mode_nxt = M_PRIMARY_RUN;
            want_src_nxt = `SRC_PRIMARY;
         end
      endcase
   end

   always @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         mode_r <= M_PRIMARY_RUN;
         want_src_r <= `SRC_PRIMARY;
         sec_off_after_r <= 1'b0;
         halt_r <= 1'b0;
         cpu_wait_r <= 1'b0;
         freq_prev_r <= `FREQ_OFF;
      end else begin
         mode_r <= mode_nxt;
         want_src_r <= want_src_nxt;
         sec_off_after_r <= sec_off_after_nxt;
         halt_r <= halt_nxt;
         cpu_wait_r <= wake_busy;
         freq_prev_r <= internal_freq_select_in;
      end
   end

   // ****************************************
   // outputs and flags
   // ****************************************
   // idle and select bits are inputs only; nothing here writes them
   always @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         primary_ready_flag_out <= 1'b1;
         internal_osc_stable_flag_out <= 1'b0;
         secondary_active_flag_out <= 1'b0;
         cpu_clk_en_out <= 1'b1;
         periph_clk_en_out <= 1'b1;
         sys_clk_src_out <= `SRC_PRIMARY;
         internal_freq_out <= `FREQ_OFF;
         primary_osc_en_out <= 1'b1;
         internal_osc_mux_en_out <= 1'b0;
         secondary_osc_run_out <= 1'b0;
         slow_internal_rc_en_out <= 1'b1;
         wdt_reset_out <= 1'b0;
         mode_out <= M_PRIMARY_RUN;
      end else begin
         mode_out <= mode_nxt;
         sys_clk_src_out <= cur_src;
         internal_freq_out <= internal_freq_select_in;
         internal_osc_mux_en_out <= freq_on && mode_nxt != M_SLEEP;
         wdt_reset_out <= is_run_mode(mode_r) && wdt_timeout_in;
         cpu_clk_en_out <= !(halt_nxt || mode_nxt == M_SLEEP || wake_busy);
         periph_clk_en_out <= (mode_nxt != M_SLEEP);
         // primary runs unless a low-power source or sleep is selected
         primary_osc_en_out <= (mode_nxt == M_PRIMARY_RUN) || (mode_nxt == M_SWITCHBACK);
         // slow rc: always when mux off, else kept for watchdog or monitor
         slow_internal_rc_en_out <= !freq_on || wdt_enable_in || fscm_enable_in;
         // secondary keeps running unless forced off by firmware exit
         if (mode_nxt == M_SECONDARY_RUN || mode_nxt == M_SECONDARY_IDLE)
            secondary_osc_run_out <= 1'b1;
         else if (sec_off_after_r && mode_nxt == M_PRIMARY_RUN)
            secondary_osc_run_out <= 1'b0;
         else if (mode_nxt == M_SWITCHBACK && sec_off_after_nxt)
            secondary_osc_run_out <= 1'b1;
         else
            secondary_osc_run_out <= secondary_osc_enable_in;
         // flags follow the completed switch in the same cycle
         if (switched) begin
            case (cur_src)
               `SRC_PRIMARY: begin
                  primary_ready_flag_out <= 1'b1;
                  secondary_active_flag_out <= 1'b0;
                  internal_osc_stable_flag_out <= 1'b0;
               end
               `SRC_SECONDARY: begin
                  primary_ready_flag_out <= 1'b0;
                  secondary_active_flag_out <= 1'b1;
                  internal_osc_stable_flag_out <= internal_osc_stable_flag_out && freq_on;
               end
               `SRC_INTERNAL: begin
                  primary_ready_flag_out <= 1'b0;
                  // kept if already stable
                  internal_osc_stable_flag_out <= mux_settled;
               end
               default: begin
                  primary_ready_flag_out <= 1'b0;
                  secondary_active_flag_out <= 1'b0;
                  internal_osc_stable_flag_out <= 1'b0;
               end
            endcase
         end else if (!freq_on) begin
            internal_osc_stable_flag_out <= 1'b0;
         end else if (mux_settled && mode_r != M_SLEEP && cur_src == `SRC_INTERNAL) begin
            internal_osc_stable_flag_out <= 1'b1;
         end
      end
   end
endmodule

// ### hw/pm_clock_regs.vh
// constants for the power-managed clock mode controller
`ifndef PM_CLOCK_REGS_VH
`define PM_CLOCK_REGS_VH
`define CLK_PERIOD_NS 100
`define STABLE_TIME_US 1000
`define STABLE_CYCLES ((`STABLE_TIME_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CPU_WAKE_TIME_US 10
`define CPU_WAKE_CYCLES ((`CPU_WAKE_TIME_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SEL_SECONDARY 2'h1
`define SEL_PRIMARY 2'h0
`define SRC_PRIMARY 2'h0
`define SRC_SECONDARY 2'h1
`define SRC_INTERNAL 2'h2
`define SRC_NONE 2'h3
`define FREQ_OFF 3'h0
`define CNT_W 16
`endif

// ### hw/pm_delay_timer.v
// reloadable down-counter giving a one-cycle done pulse
`timescale 1ns/1ps
module pm_delay_timer (
   // clock and reset
   input wire core_clk_in,
   input wire reset_n_in,
   // control
   input wire start_in,
   input wire abort_in,
   input wire [15:0] load_in,
   // status
   output reg busy_out,
   output reg done_out
);
   reg [15:0] count_r;

   always @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         count_r <= 16'h0000;
         busy_out <= 1'b0;
         done_out <= 1'b0;
      end else begin
         done_out <= 1'b0;
         if (abort_in) begin
            busy_out <= 1'b0;
            count_r <= 16'h0000;
         end else if (start_in) begin
            busy_out <= 1'b1;
            count_r <= load_in;
         end else if (busy_out) begin
            if (count_r <= 16'h0001) begin
               busy_out <= 1'b0;
               done_out <= 1'b1;
            end
            count_r <= count_r - 16'h0001;
         end
      end
   end
endmodule

// ### verif/pm_clock_modes_chk.sv
// assertion checker for the power-managed clock mode controller
`timescale 1ns/1ps
module pm_clock_modes_chk (
   // clock, reset and core requests
   input logic core_clk_in, reset_n_in, sleep_exec_in, wake_event_in, wdt_timeout_in,
   // control bits
   input logic idle_enable_in, secondary_osc_enable_in,
   input logic [1:0] source_select_in,
   input logic [2:0] internal_freq_select_in,
   // watched outputs
   input logic primary_ready_flag_out, internal_osc_stable_flag_out, secondary_active_flag_out,
   input logic cpu_clk_en_out, periph_clk_en_out, primary_osc_en_out, wdt_reset_out,
   input logic [1:0] sys_clk_src_out,
   input logic [2:0] internal_freq_out,
   input logic [6:0] mode_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!reset_n_in);
   // a sleep only counts when no higher-priority event shares its cycle
   wire go = sleep_exec_in && !wdt_timeout_in && !wake_event_in;
   wire pr = mode_out == 7'h01 && go && !idle_enable_in;
   wire [2:0] flags = {primary_ready_flag_out, internal_osc_stable_flag_out,
      secondary_active_flag_out};

   chk_pri_ready: assert property (mode_out == 7'h01 |-> primary_ready_flag_out)
      else $error("primary run without ready flag");
   chk_int_pri_off: assert property ((mode_out == 7'h04 || mode_out == 7'h08)
      |-> !primary_osc_en_out) else $error("primary oscillator on in internal mode");
   chk_sec_refused: assert property (pr && source_select_in == 2'h1
      && !secondary_osc_enable_in |=> mode_out == 7'h01) else $error("secondary sleep taken");
   chk_int_run_entry: assert property (pr && source_select_in[1] |=> mode_out == 7'h04
      ##2 sys_clk_src_out == 2'h3 ##1 (sys_clk_src_out == 2'h2 && !primary_ready_flag_out))
      else $error("internal run entry wrong");
   chk_sec_entry: assert property (pr && source_select_in == 2'h1 && secondary_osc_enable_in
      |=> mode_out == 7'h02 ##3 (sys_clk_src_out == 2'h1 && flags == 3'b001))
      else $error("secondary run entry wrong");
   chk_sleep_entry: assert property (pr && source_select_in == 2'h0
      |=> mode_out == 7'h20 ##[1:3] (flags == 3'b000 && !primary_osc_en_out))
      else $error("sleep entry wrong");
   chk_idle_hold: assert property (mode_out == 7'h04 && go && idle_enable_in
      |=> mode_out == 7'h08 && $stable(flags) && !cpu_clk_en_out && periph_clk_en_out)
      else $error("run to idle wrong");
   chk_wdt_reset: assert property ((mode_out == 7'h02 || mode_out == 7'h04)
      && wdt_timeout_in |=> wdt_reset_out) else $error("no watchdog reset in run mode");
   chk_cpu_delay: assert property (mode_out == 7'h08 && wake_event_in
      |=> !cpu_clk_en_out [*8] ##[80:100] cpu_clk_en_out) else $error("cpu wake delay wrong");
   chk_freq_copy: assert property (internal_freq_out == $past(internal_freq_select_in))
      else $error("frequency select not applied");
   chk_back_flags: assert property (sys_clk_src_out == 2'h0
      && $past(sys_clk_src_out) != 2'h0 |-> flags == 3'b100) else $error("switchback flags");
   chk_zero_freq: assert property (internal_freq_select_in == 3'h0 [*2]
      |-> !internal_osc_stable_flag_out) else $error("stable flag with mux off");

   cover property (mode_out == 7'h02);
   cover property (mode_out == 7'h08 ##1 mode_out != 7'h08);
   cover property (mode_out == 7'h20);
endmodule

bind pm_clock_modes pm_clock_modes_chk u_chk (.core_clk_in(core_clk_in),
   .reset_n_in(reset_n_in), .sleep_exec_in(sleep_exec_in), .wake_event_in(wake_event_in),
   .wdt_timeout_in(wdt_timeout_in), .idle_enable_in(idle_enable_in),
   .secondary_osc_enable_in(secondary_osc_enable_in), .source_select_in(source_select_in),
   .internal_freq_select_in(internal_freq_select_in),
   .primary_ready_flag_out(primary_ready_flag_out),
   .internal_osc_stable_flag_out(internal_osc_stable_flag_out),
   .secondary_active_flag_out(secondary_active_flag_out), .cpu_clk_en_out(cpu_clk_en_out),
   .periph_clk_en_out(periph_clk_en_out), .primary_osc_en_out(primary_osc_en_out),
   .wdt_reset_out(wdt_reset_out), .sys_clk_src_out(sys_clk_src_out),
   .internal_freq_out(internal_freq_out), .mode_out(mode_out));

// ### verif/primary_osc_model.sv
// primary oscillator start-up model: ready some cycles after enable
`timescale 1ns/1ps
module primary_osc_model #(parameter int START_CYC = 20) (
   input logic core_clk_in, reset_n_in, osc_en_in,
   output logic osc_ready_out
);
   int cnt_r;
   // stopping drops ready at once: no warm restart is modelled
   always @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in || !osc_en_in) begin
         cnt_r <= 0;
         osc_ready_out <= 1'b0;
      end else if (cnt_r == START_CYC) begin
         osc_ready_out <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 1;
      end
   end
endmodule

// ### verif/tb_top.sv
// self-checking testbench for the power-managed clock mode controller
`timescale 1ns/1ps
module tb_top;
   logic core_clk_in = 1'b0, reset_n_in = 1'b0;
   logic sleep_exec_in = 1'b0, wake_event_in = 1'b0, wdt_timeout_in = 1'b0;
   logic idle_enable_in = 1'b0, secondary_osc_enable_in = 1'b0;
   logic wdt_enable_in = 1'b1, fscm_enable_in = 1'b1;
   logic [1:0] source_select_in = 2'h0;
   logic [2:0] internal_freq_select_in = 3'h0;
   wire osc_rdy, pri_f, stb_f, sec_f, cpu_en, per_en, posc_en, mux_en, secondary_run, rc_en, wdt_rst;
   wire [1:0] src;
   wire [2:0] freq;
   wire [6:0] mode;
   wire [2:0] flags = {pri_f, stb_f, sec_f};
   int num_errors = 0, n_checks = 0, cyc = 0;

   pm_clock_modes u_dut (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
      .sleep_exec_in(sleep_exec_in), .wake_event_in(wake_event_in),
      .wdt_timeout_in(wdt_timeout_in), .idle_enable_in(idle_enable_in),
      .source_select_in(source_select_in), .internal_freq_select_in(internal_freq_select_in),
      .secondary_osc_enable_in(secondary_osc_enable_in), .wdt_enable_in(wdt_enable_in),
      .fscm_enable_in(fscm_enable_in), .primary_osc_ready_in(osc_rdy),
      .primary_ready_flag_out(pri_f), .internal_osc_stable_flag_out(stb_f),
      .secondary_active_flag_out(sec_f), .cpu_clk_en_out(cpu_en), .periph_clk_en_out(per_en),
      .sys_clk_src_out(src), .internal_freq_out(freq), .primary_osc_en_out(posc_en),
      .internal_osc_mux_en_out(mux_en), .secondary_osc_run_out(secondary_run),
      .slow_internal_rc_en_out(rc_en), .wdt_reset_out(wdt_rst), .mode_out(mode));
   primary_osc_model u_osc (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
      .osc_en_in(posc_en), .osc_ready_out(osc_rdy));

   initial begin
      forever #50 core_clk_in = ~core_clk_in;
   end

   // about 21k cycles of work; the ceiling leaves ample slack
   always @(posedge core_clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         num_errors = num_errors + 1;
         test_done();
      end
   end

   task test_done();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task cmp(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_checks = n_checks + 1;
      if (seen !== exp) begin
         num_errors = num_errors + 1;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task cycles(input int n);
      repeat (n) @(negedge core_clk_in);
   endtask

   task automatic pulse(ref logic s);
      s = 1'b1;
      @(negedge core_clk_in);
      s = 1'b0;
   endtask

   task sleep_op(input logic idle, input logic [1:0] sel);
      idle_enable_in = idle;
      source_select_in = sel;
      pulse(sleep_exec_in);
   endtask

   task wait_mode(input logic [6:0] m);
      int k;
      k = 0;
      while (mode !== m && k < 2000) begin
         @(negedge core_clk_in);
         k = k + 1;
      end
      cmp("mode", 8'(mode), 8'(m));
   endtask

   initial begin
      cycles(20);
      reset_n_in = 1'b1;
      cycles(1);
      wait_mode(7'h01);
      cmp("flags", 8'(flags), 8'h04);
      sleep_op(1'b0, 2'h1);
      cycles(5);
      wait_mode(7'h01);
      secondary_osc_enable_in = 1'b1;
      sleep_op(1'b0, 2'h1);
      wait_mode(7'h02);
      cycles(4);
      cmp("src", 8'(src), 8'h01);
      cmp("flags", 8'(flags), 8'h01);
      cmp("posc_en", 8'(posc_en), 8'h00);
      secondary_osc_enable_in = 1'b0;
      wait_mode(7'h01);
      cycles(2);
      cmp("flags", 8'(flags), 8'h04);
      cmp("secondary_run", 8'(secondary_run), 8'h00);
      secondary_osc_enable_in = 1'b1;
      sleep_op(1'b0, 2'h1);
      wait_mode(7'h02);
      pulse(wake_event_in);
      wait_mode(7'h01);
      cycles(2);
      cmp("secondary_run", 8'(secondary_run), 8'h01);
      cmp("flags", 8'(flags), 8'h04);
      // lower select bit set on purpose: it must not matter
      internal_freq_select_in = 3'h5;
      sleep_op(1'b0, 2'h3);
      wait_mode(7'h04);
      cycles(3);
      cmp("src", 8'(src), 8'h02);
      cmp("flags", 8'(flags), 8'h00);
      cmp("posc_en", 8'(posc_en), 8'h00);
      cmp("cpu_en", 8'(cpu_en), 8'h01);
      cycles(9800);
      cmp("stable", 8'(stb_f), 8'h00);
      cycles(300);
      cmp("stable", 8'(stb_f), 8'h01);
      internal_freq_select_in = 3'h6;
      cycles(1);
      cmp("freq", 8'(freq), 8'h06);
      sleep_op(1'b1, 2'h2);
      wait_mode(7'h08);
      cmp("flags", 8'(flags), 8'h02);
      cmp("cpu_en", 8'(cpu_en), 8'h00);
      cmp("per_en", 8'(per_en), 8'h01);
      pulse(wake_event_in);
      cycles(50);
      cmp("cpu_en", 8'(cpu_en), 8'h00);
      cmp("per_en", 8'(per_en), 8'h01);
      cycles(70);
      cmp("cpu_en", 8'(cpu_en), 8'h01);
      wait_mode(7'h01);
      cycles(2);
      cmp("flags", 8'(flags), 8'h04);
      cmp("rc_en", 8'(rc_en), 8'h01);
      internal_freq_select_in = 3'h0;
      sleep_op(1'b0, 2'h2);
      wait_mode(7'h04);
      cycles(10100);
      cmp("mux_en", 8'(mux_en), 8'h00);
      cmp("stable", 8'(stb_f), 8'h00);
      pulse(wdt_timeout_in);
      cmp("wdt_rst", 8'(wdt_rst), 8'h01);
      pulse(wake_event_in);
      wait_mode(7'h01);
      sleep_op(1'b0, 2'h0);
      wait_mode(7'h20);
      cycles(4);
      cmp("flags", 8'(flags), 8'h00);
      cmp("posc_en", 8'(posc_en), 8'h00);
      cmp("secondary_run", 8'(secondary_run), 8'h01);
      cmp("rc_en", 8'(rc_en), 8'h01);
      pulse(wake_event_in);
      wait_mode(7'h01);
      cycles(2);
      cmp("flags", 8'(flags), 8'h04);
      sleep_op(1'b1, 2'h1);
      wait_mode(7'h10);
      cmp("cpu_en", 8'(cpu_en), 8'h00);
      pulse(wake_event_in);
      wait_mode(7'h01);
      sleep_op(1'b1, 2'h2);
      wait_mode(7'h08);
      cmp("cpu_en", 8'(cpu_en), 8'h00);
      pulse(wdt_timeout_in);
      wait_mode(7'h01);
      test_done();
   end
endmodule
